// ===== pkg/gpio_ef_pkg.sv
// Package with register map, field positions, reset values and carriers for ports E and F.
`default_nettype none
package gpio_ef_pkg;

   // Register indices on the plain register port.
   localparam logic [3:0] ADDR_E_DIR      = 4'h0;
   localparam logic [3:0] ADDR_E_PINS     = 4'h1;
   localparam logic [3:0] ADDR_E_LAT      = 4'h2;
   localparam logic [3:0] ADDR_MEM_CTL    = 4'h3;
   localparam logic [3:0] ADDR_SP_CTL     = 4'h4;
   localparam logic [3:0] ADDR_F_DIR      = 4'h5;
   localparam logic [3:0] ADDR_F_PINS     = 4'h6;
   localparam logic [3:0] ADDR_F_LAT      = 4'h7;
   localparam logic [3:0] ADDR_ANALOG_CFG = 4'h8;
   localparam logic [3:0] ADDR_CMP_CTL    = 4'h9;
   localparam logic [3:0] ADDR_CMP_REF    = 4'ha;
   localparam logic [3:0] ADDR_SLAVE_DATA = 4'hb;
   localparam logic [3:0] ADDR_DEV_CFG    = 4'hc;

   // Field positions.
   localparam int MEM_BUS_DIS_BIT = 7;
   localparam int SP_IN_FULL_BIT  = 7;
   localparam int SP_OUT_FULL_BIT = 6;
   localparam int SP_OVERRUN_BIT  = 5;
   localparam int SP_MODE_BIT     = 4;
   localparam int CMP_TWO_OUT_BIT = 7;
   localparam int CMP_ONE_OUT_BIT = 6;
   localparam int CFG_UC_MODE_BIT = 0;
   localparam int CFG_RELOC_BIT   = 1;
   localparam int CFG_CCP_E7_BIT  = 2;
   localparam int E_READ_BIT      = 0;
   localparam int E_WRITE_BIT     = 1;
   localparam int E_SELECT_BIT    = 2;
   localparam int E_PWM_C_BIT     = 5;
   localparam int E_PWM_B_BIT     = 6;
   localparam int E_CCP_BIT       = 7;
   localparam int F_CMP_TWO_BIT   = 1;
   localparam int F_CMP_ONE_BIT   = 2;
   localparam int F_SELECT_BIT    = 7;
   localparam int F_FIRST_CHAN    = 5;

   // Writable masks and reset values.
   localparam logic [7:0] MEM_CTL_WMASK   = 8'hb3;
   localparam logic [7:0] ANALOG_CFG_MASK = 8'h3f;
   localparam logic [7:0] CMP_CTL_WMASK   = 8'h3f;
   localparam logic [7:0] CMP_IN_PINS     = 8'h78;
   localparam logic [7:0] DIR_RST         = 8'hff;
   localparam logic [7:0] ZERO_RST        = 8'h00;
   localparam logic [7:0] DEV_CFG_RST     = 8'h01;
   localparam logic [2:0] CMP_MODE_OFF    = 3'h7;
   localparam logic [2:0] CMP_MODE_OUT    = 3'h6;
   localparam logic [3:0] PCFG_TOP        = 4'hf;

   // Software-visible register state.
   typedef struct packed {
      logic [7:0] eDir;
      logic [7:0] eLat;
      logic [7:0] memCtl;
      logic [7:0] spCtl;
      logic [7:0] fDir;
      logic [7:0] fLat;
      logic [7:0] anCfg;
      logic [7:0] cmpCtl;
      logic [7:0] cmpRef;
      logic [7:0] slaveIn;
      logic [7:0] slaveOut;
      logic [7:0] devCfg;
   } regs_t;

   // Drive of one 8-bit port.
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;

endpackage : gpio_ef_pkg
`default_nettype wire

// ===== verilog/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   // The first stage feeds only the second, to keep metastability out of the logic.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= async;
         stage2_q <= stage1_q;
      end
   end

   assign synced = stage2_q;

endmodule : pin_sync
`default_nettype wire

// ===== verilog/gpio_pin_mux.sv
// Per-bit mux between the port latch and an alternate function for one port.
`default_nettype none
`timescale 1ns/10ps
module gpio_pin_mux (
   input  wire logic [7:0]               lat,
   input  wire logic [7:0]               dir,
   input  wire logic [7:0]               altEn,
   input  wire logic [7:0]               altOut,
   input  wire logic [7:0]               altOe,
   output gpio_ef_pkg::pin_drive_t       drive
);

   // A set direction bit releases the pin; an active alternate function overrides both.
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign drive.out[i] = altEn[i] ? altOut[i] : lat[i];
      assign drive.oe[i]  = altEn[i] ? altOe[i] : ~dir[i];
   end

endmodule : gpio_pin_mux
`default_nettype wire

// ===== verilog/gpio_ports_e_f.sv
// Ports E and F: registers, pin muxing and the slave port strobe logic.
`default_nettype none
`timescale 1ns/10ps
module gpio_ports_e_f (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   input  wire logic [7:0] portEIn,
   output logic      [7:0] portEOut,
   output logic      [7:0] portEOe,
   input  wire logic [7:0] portFIn,
   output logic      [7:0] portFOut,
   output logic      [7:0] portFOe,
   input  wire logic [7:0] slaveDataIn,
   output logic      [7:0] slaveDataOut,
   output logic            slaveDataOe,
   input  wire logic [7:0] extBusOut,
   input  wire logic       extBusOe,
   output logic      [7:0] extBusIn,
   output logic            extBusActive,
   input  wire logic       pwmEnable,
   input  wire logic       pwmB,
   input  wire logic       pwmC,
   input  wire logic       ccpOut,
   input  wire logic       ccpOe,
   output logic            ccpIn,
   input  wire logic       cmpOneResult,
   input  wire logic       cmpTwoResult,
   output logic            serialSelectN
);

   gpio_ef_pkg::regs_t      regs_q;
   gpio_ef_pkg::regs_t      regs_d;
   gpio_ef_pkg::pin_drive_t eDrive;
   gpio_ef_pkg::pin_drive_t fDrive;
   gpio_ef_pkg::pin_drive_t eDrive_q;
   gpio_ef_pkg::pin_drive_t fDrive_q;
   logic [7:0] rdData_q;
   logic [7:0] rdData_d;
   logic [7:0] ePins;
   logic [7:0] fPins;
   logic [7:0] dPins;
   logic [7:0] fDigital;
   logic [7:0] fRead;
   logic [7:0] eAltEn;
   logic [7:0] eAltOut;
   logic [7:0] eAltOe;
   logic [7:0] fAltEn;
   logic [7:0] fAltOut;
   logic [7:0] fAltOe;
   logic [7:0] wrHold_q;
   logic [7:0] wrHold_d;
   logic       wrAct_q;
   logic       rdAct_q;
   logic       busActive;
   logic       slaveMode;
   logic       cmpOn;
   logic       cmpOutMode;
   logic       wrAct;
   logic       rdAct;
   logic       wrEnd;
   logic       rdEnd;
   logic [3:0] pcfg;

   // Every pin input crosses into the clock domain before any logic looks at it.
   pin_sync #(.WIDTH(8)) u_sync_e (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .async   (portEIn),
      .synced  (ePins)
   );

   pin_sync #(.WIDTH(8)) u_sync_f (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .async   (portFIn),
      .synced  (fPins)
   );

   pin_sync #(.WIDTH(8)) u_sync_d (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .async   (slaveDataIn),
      .synced  (dPins)
   );

   // Mode decode from the control registers.
   assign busActive  = ~regs_q.memCtl[gpio_ef_pkg::MEM_BUS_DIS_BIT];
   assign slaveMode  = regs_q.spCtl[gpio_ef_pkg::SP_MODE_BIT]
                       & regs_q.devCfg[gpio_ef_pkg::CFG_UC_MODE_BIT]
                       & ~busActive;
   assign cmpOn      = regs_q.cmpCtl[2:0] != gpio_ef_pkg::CMP_MODE_OFF;
   assign cmpOutMode = regs_q.cmpCtl[2:0] == gpio_ef_pkg::CMP_MODE_OUT;
   assign pcfg       = regs_q.anCfg[3:0];

   // Host strobes are only honoured while chip select is low.
   assign rdAct = slaveMode & ~ePins[gpio_ef_pkg::E_SELECT_BIT]
                  & ~ePins[gpio_ef_pkg::E_READ_BIT];
   assign wrAct = slaveMode & ~ePins[gpio_ef_pkg::E_SELECT_BIT]
                  & ~ePins[gpio_ef_pkg::E_WRITE_BIT];
   assign wrEnd = wrAct_q & ~wrAct;
   assign rdEnd = rdAct_q & ~rdAct;

   // Port E alternate functions, highest priority first: bus, slave strobes, PWM, capture.
   always_comb begin
      eAltEn  = 8'h00;
      eAltOut = 8'h00;
      eAltOe  = 8'h00;
      if (busActive) begin
         eAltEn  = 8'hff;
         eAltOut = extBusOut;
         eAltOe  = {8{extBusOe}};
      end else begin
         if (slaveMode) begin
            eAltEn[2:0] = 3'h7;
         end
         if (pwmEnable && !regs_q.devCfg[gpio_ef_pkg::CFG_RELOC_BIT]) begin
            eAltEn[gpio_ef_pkg::E_PWM_C_BIT]  = 1'b1;
            eAltEn[gpio_ef_pkg::E_PWM_B_BIT]  = 1'b1;
            eAltOut[gpio_ef_pkg::E_PWM_C_BIT] = pwmC;
            eAltOut[gpio_ef_pkg::E_PWM_B_BIT] = pwmB;
            eAltOe[gpio_ef_pkg::E_PWM_C_BIT]  = 1'b1;
            eAltOe[gpio_ef_pkg::E_PWM_B_BIT]  = 1'b1;
         end
         if (regs_q.devCfg[gpio_ef_pkg::CFG_UC_MODE_BIT]
             && regs_q.devCfg[gpio_ef_pkg::CFG_CCP_E7_BIT]) begin
            eAltEn[gpio_ef_pkg::E_CCP_BIT]  = 1'b1;
            eAltOut[gpio_ef_pkg::E_CCP_BIT] = ccpOut;
            eAltOe[gpio_ef_pkg::E_CCP_BIT]  = ccpOe;
         end
      end
   end

   // Port F alternate outputs: the two comparator results.
   always_comb begin
      fAltEn  = 8'h00;
      fAltOut = 8'h00;
      fAltOe  = 8'h00;
      if (cmpOutMode) begin
         fAltEn[gpio_ef_pkg::F_CMP_TWO_BIT]  = 1'b1;
         fAltEn[gpio_ef_pkg::F_CMP_ONE_BIT]  = 1'b1;
         fAltOut[gpio_ef_pkg::F_CMP_TWO_BIT] = cmpTwoResult;
         fAltOut[gpio_ef_pkg::F_CMP_ONE_BIT] = cmpOneResult;
         fAltOe[gpio_ef_pkg::F_CMP_TWO_BIT]  = 1'b1;
         fAltOe[gpio_ef_pkg::F_CMP_ONE_BIT]  = 1'b1;
      end
   end

   // Analog pins read as zero; a channel is analog while it lies below the config limit.
   for (genvar i = 0; i < 8; i++) begin : g_fdig
      if (i == gpio_ef_pkg::F_SELECT_BIT) begin : g_plain
         assign fDigital[i] = 1'b1;
      end else begin : g_chan
         assign fDigital[i] = (5'(i + gpio_ef_pkg::F_FIRST_CHAN)
                               >= 5'(gpio_ef_pkg::PCFG_TOP - pcfg))
                              & ~(cmpOn & gpio_ef_pkg::CMP_IN_PINS[i]);
      end
   end
   assign fRead = fPins & fDigital;

   gpio_pin_mux u_mux_e (
      .lat    (regs_q.eLat),
      .dir    (regs_q.eDir),
      .altEn  (eAltEn),
      .altOut (eAltOut),
      .altOe  (eAltOe),
      .drive  (eDrive)
   );

   gpio_pin_mux u_mux_f (
      .lat    (regs_q.fLat),
      .dir    (regs_q.fDir),
      .altEn  (fAltEn),
      .altOut (fAltOut),
      .altOe  (fAltOe),
      .drive  (fDrive)
   );

   // Register writes, slave port flags and read data. Every flag set wins over its clear.
   always_comb begin
      regs_d   = regs_q;
      rdData_d = 8'h00;
      wrHold_d = wrAct ? dPins : wrHold_q;
      if (rdEnd) begin
         regs_d.spCtl[gpio_ef_pkg::SP_OUT_FULL_BIT] = 1'b0;
      end
      if (regWr) begin
         unique case (regAddr)
            gpio_ef_pkg::ADDR_E_DIR:      regs_d.eDir = regWrData;
            gpio_ef_pkg::ADDR_E_PINS:     regs_d.eLat = regWrData;
            gpio_ef_pkg::ADDR_E_LAT:      regs_d.eLat = regWrData;
            gpio_ef_pkg::ADDR_MEM_CTL:
               regs_d.memCtl = regWrData & gpio_ef_pkg::MEM_CTL_WMASK;
            gpio_ef_pkg::ADDR_SP_CTL: begin
               regs_d.spCtl[gpio_ef_pkg::SP_MODE_BIT] = regWrData[gpio_ef_pkg::SP_MODE_BIT];
               if (!regWrData[gpio_ef_pkg::SP_OVERRUN_BIT]) begin
                  regs_d.spCtl[gpio_ef_pkg::SP_OVERRUN_BIT] = 1'b0;
               end
            end
            gpio_ef_pkg::ADDR_F_DIR:      regs_d.fDir = regWrData;
            gpio_ef_pkg::ADDR_F_PINS:     regs_d.fLat = regWrData;
            gpio_ef_pkg::ADDR_F_LAT:      regs_d.fLat = regWrData;
            gpio_ef_pkg::ADDR_ANALOG_CFG:
               regs_d.anCfg = regWrData & gpio_ef_pkg::ANALOG_CFG_MASK;
            gpio_ef_pkg::ADDR_CMP_CTL:
               regs_d.cmpCtl[5:0] = regWrData[5:0] & gpio_ef_pkg::CMP_CTL_WMASK[5:0];
            gpio_ef_pkg::ADDR_CMP_REF:    regs_d.cmpRef = regWrData;
            gpio_ef_pkg::ADDR_SLAVE_DATA: begin
               regs_d.slaveOut = regWrData;
               regs_d.spCtl[gpio_ef_pkg::SP_OUT_FULL_BIT] = 1'b1;
            end
            gpio_ef_pkg::ADDR_DEV_CFG:    regs_d.devCfg = regWrData;
            default: ;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            gpio_ef_pkg::ADDR_E_DIR:      rdData_d = regs_q.eDir;
            gpio_ef_pkg::ADDR_E_PINS:     rdData_d = ePins;
            gpio_ef_pkg::ADDR_E_LAT:      rdData_d = regs_q.eLat;
            gpio_ef_pkg::ADDR_MEM_CTL:    rdData_d = regs_q.memCtl;
            gpio_ef_pkg::ADDR_SP_CTL:     rdData_d = regs_q.spCtl;
            gpio_ef_pkg::ADDR_F_DIR:      rdData_d = regs_q.fDir;
            gpio_ef_pkg::ADDR_F_PINS:     rdData_d = fRead;
            gpio_ef_pkg::ADDR_F_LAT:      rdData_d = regs_q.fLat;
            gpio_ef_pkg::ADDR_ANALOG_CFG: rdData_d = regs_q.anCfg;
            gpio_ef_pkg::ADDR_CMP_CTL:    rdData_d = regs_q.cmpCtl;
            gpio_ef_pkg::ADDR_CMP_REF:    rdData_d = regs_q.cmpRef;
            gpio_ef_pkg::ADDR_SLAVE_DATA: begin
               rdData_d = regs_q.slaveIn;
               regs_d.spCtl[gpio_ef_pkg::SP_IN_FULL_BIT] = 1'b0;
            end
            gpio_ef_pkg::ADDR_DEV_CFG:    rdData_d = regs_q.devCfg;
            default:                      rdData_d = 8'h00;
         endcase
      end
      // Comparator results are status and follow the comparators every cycle.
      regs_d.cmpCtl[gpio_ef_pkg::CMP_TWO_OUT_BIT] = cmpTwoResult;
      regs_d.cmpCtl[gpio_ef_pkg::CMP_ONE_OUT_BIT] = cmpOneResult;
      // The host's data is taken when its write strobe ends, as on a real latch.
      if (wrEnd) begin
         regs_d.slaveIn = wrHold_q;
         if (regs_q.spCtl[gpio_ef_pkg::SP_IN_FULL_BIT]) begin
            regs_d.spCtl[gpio_ef_pkg::SP_OVERRUN_BIT] = 1'b1;
         end
         regs_d.spCtl[gpio_ef_pkg::SP_IN_FULL_BIT] = 1'b1;
      end
   end

   // All state outside the synchronisers is registered here; extBusIn, ccpIn and serialSelectN come straight from them.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         regs_q.eDir     <= gpio_ef_pkg::DIR_RST;
         regs_q.eLat     <= gpio_ef_pkg::ZERO_RST;
         regs_q.memCtl   <= gpio_ef_pkg::ZERO_RST;
         regs_q.spCtl    <= gpio_ef_pkg::ZERO_RST;
         regs_q.fDir     <= gpio_ef_pkg::DIR_RST;
         regs_q.fLat     <= gpio_ef_pkg::ZERO_RST;
         regs_q.anCfg    <= gpio_ef_pkg::ZERO_RST;
         regs_q.cmpCtl   <= gpio_ef_pkg::ZERO_RST;
         regs_q.cmpRef   <= gpio_ef_pkg::ZERO_RST;
         regs_q.slaveIn  <= gpio_ef_pkg::ZERO_RST;
         regs_q.slaveOut <= gpio_ef_pkg::ZERO_RST;
         regs_q.devCfg   <= gpio_ef_pkg::DEV_CFG_RST;
         rdData_q        <= 8'h00;
         wrHold_q        <= 8'h00;
         wrAct_q         <= 1'b0;
         rdAct_q         <= 1'b0;
         eDrive_q        <= '0;
         fDrive_q        <= '0;
         extBusActive    <= 1'b0;
      end else begin
         regs_q       <= regs_d;
         rdData_q     <= rdData_d;
         wrHold_q     <= wrHold_d;
         wrAct_q      <= wrAct;
         rdAct_q      <= rdAct;
         eDrive_q     <= eDrive;
         fDrive_q     <= fDrive;
         extBusActive <= busActive;
      end
   end

   assign regRdData     = rdData_q;
   assign portEOut      = eDrive_q.out;
   assign portEOe       = eDrive_q.oe;
   assign portFOut      = fDrive_q.out;
   assign portFOe       = fDrive_q.oe;
   assign slaveDataOut  = regs_q.slaveOut;
   assign slaveDataOe   = rdAct_q;
   assign extBusIn      = ePins;
   assign ccpIn         = ePins[gpio_ef_pkg::E_CCP_BIT];
   assign serialSelectN = fPins[gpio_ef_pkg::F_SELECT_BIT];

endmodule : gpio_ports_e_f
`default_nettype wire

// ===== tb/gpio_ports_e_f_props.sv
// Concurrent checks on the port E/F block, seen from its top-level ports only.
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_e_f_props (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   input  wire logic [7:0] regRdData,
   input  wire logic [7:0] portEOut,
   input  wire logic [7:0] portEOe,
   input  wire logic [7:0] portEIn,
   input  wire logic [7:0] portFOe,
   input  wire logic [7:0] portFIn,
   input  wire logic [7:0] extBusOut,
   input  wire logic       extBusOe,
   input  wire logic       extBusActive,
   input  wire logic       slaveDataOe,
   input  wire logic       serialSelectN
);
   // One clock domain, so clocking and reset gating are declared once.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Register port answers and direction effects.
   chk_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data seen outside the answer cycle");
   chk_latch_readback: assert property (regWr && (regAddr == gpio_ef_pkg::ADDR_F_LAT || regAddr == gpio_ef_pkg::ADDR_F_PINS) ##1 !regWr ##1 regRd && regAddr == gpio_ef_pkg::ADDR_F_LAT |=> regRdData == $past(regWrData, 3))
      else $error("port F latch read does not return written value");
   chk_dir_release: assert property (regWr && regAddr == gpio_ef_pkg::ADDR_F_DIR ##1 !(regWr && regAddr == gpio_ef_pkg::ADDR_F_DIR) |=> (portFOe & 8'hf9) == (~$past(regWrData, 2) & 8'hf9))
      else $error("port F enables do not follow direction write");
   chk_reset_inputs: assert property (!$past(resetn) |-> portFOe == 8'h00)
      else $error("port F drives a pin after reset");
   chk_pin_readback: assert property ($stable(portFIn[7]) [*4] ##0 (regRd && regAddr == gpio_ef_pkg::ADDR_F_PINS) |=> regRdData[7] == $past(portFIn[7]))
      else $error("port F pins read not the pin level");

   // Alternate functions on the pins.
   chk_bus_high_byte: assert property (extBusActive && $past(extBusActive) |-> portEOe == {8{$past(extBusOe)}} && (portEOut & portEOe) == ($past(extBusOut) & portEOe))
      else $error("port E does not carry the bus high byte");
   chk_select_gate: assert property ($rose(slaveDataOe) |-> $past(portEIn[2], 3) == 1'b0 && $past(portEIn[0], 3) == 1'b0)
      else $error("slave read answered without select and strobe");
   chk_read_release: assert property ($rose(portEIn[0]) |-> ##[1:6] !slaveDataOe)
      else $error("slave data still driven after read strobe ended");
   chk_serial_select: assert property ($stable(portFIn[7]) [*5] |-> serialSelectN == portFIn[7])
      else $error("serial select does not follow its pin");
endmodule : gpio_ports_e_f_props
`default_nettype wire

// ===== tb/pin_host_model.sv
// External host and pin logic sitting on the port E, port F and slave data pins.
`timescale 1ns/10ps
`default_nettype none
module pin_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] portEOut,
   input  wire logic [7:0] portEOe,
   input  wire logic [7:0] portFOut,
   input  wire logic [7:0] portFOe,
   input  wire logic [7:0] slaveDataOut,
   input  wire logic       slaveDataOe,
   output logic      [7:0] portEIn,
   output logic      [7:0] portFIn,
   output logic      [7:0] slaveDataIn
);
   logic [7:0] eDrive;
   logic [7:0] fDrive;
   logic [7:0] dataDrive;

   initial begin
      eDrive = 8'hff;
      fDrive = 8'hff;
      dataDrive = 8'h00;
   end

   // Port E and F wires show the device where it drives, else the host's own level; the data pins carry only the host's.
   assign portEIn = (portEOe & portEOut) | (~portEOe & eDrive);
   assign portFIn = (portFOe & portFOut) | (~portFOe & fDrive);
   assign slaveDataIn = dataDrive;

   // One strobe cycle; data stays four cycles past release so capture at strobe end is safe.
   task automatic host_cycle(input int strobeBit, input logic selN, input logic [7:0] d,
                             output logic oeSeen, output logic [7:0] dSeen);
      @(posedge ref_clk);
      eDrive[2] <= selN;
      eDrive[strobeBit] <= 1'b0;
      dataDrive <= d;
      repeat (8) @(posedge ref_clk);
      oeSeen = slaveDataOe;
      dSeen = slaveDataOut;
      eDrive[2:0] <= 3'b111;
      repeat (4) @(posedge ref_clk);
      dataDrive <= ~d;
      repeat (8) @(posedge ref_clk);
   endtask : host_cycle
endmodule : pin_host_model
`default_nettype wire

// ===== tb/gpio_ports_e_f_bench.sv
// Self-checking bench for the port E/F block with its host pin model.
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_e_f_bench;
   logic       ref_clk = 1'b0;
   logic       resetn = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   logic [7:0] extBusOut = 8'h3c;
   logic       extBusOe = 1'b1;
   logic       pwmEnable = 1'b0;
   logic       pwmB = 1'b0;
   logic       pwmC = 1'b0;
   logic       ccpOut = 1'b0;
   logic       ccpOe = 1'b0;
   logic       cmpOneResult = 1'b0;
   logic       cmpTwoResult = 1'b0;
   wire  [7:0] regRdData, portEIn, portEOut, portEOe, portFIn, portFOut, portFOe;
   wire  [7:0] slaveDataIn, slaveDataOut, extBusIn;
   wire        slaveDataOe, extBusActive, ccpIn, serialSelectN;
   logic [7:0] rv [14];
   logic [7:0] d;
   logic       o;
   int         fails = 0;
   int         checked = 0;

   always #12.5 ref_clk = ~ref_clk;

   gpio_ports_e_f gpio_ports_e_f_i (.ref_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .portEIn, .portEOut, .portEOe, .portFIn, .portFOut, .portFOe, .slaveDataIn,
      .slaveDataOut, .slaveDataOe, .extBusOut, .extBusOe, .extBusIn, .extBusActive, .pwmEnable,
      .pwmB, .pwmC, .ccpOut, .ccpOe, .ccpIn, .cmpOneResult, .cmpTwoResult, .serialSelectN);

   pin_host_model pin_host_model_i (.ref_clk, .portEOut, .portEOe, .portFOut, .portFOe,
      .slaveDataOut, .slaveDataOe, .portEIn, .portFIn, .slaveDataIn);

   // Register port cycles: one-cycle strobes, read data taken in the answer cycle.
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      cmp(regRdData, exp);
   endtask : rchk

   // Waiting at the falling edge lets every update of the last rising edge land.
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // Cuts a hang short well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      $display("ERROR %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      // Reset values by index; index 1 reads bus-driven pins and is skipped, 13 is unmapped.
      rv = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
             8'h00, 8'h01, 8'h00};
      for (int i = 0; i < 14; i++) if (i != 1) rchk(4'(i), rv[i]);
      wr(4'hd, 8'h5a);
      rchk(4'hd, 8'h00);
      cmp(portFOe, 8'h00);
      $display("reset test done");
      wr(gpio_ef_pkg::ADDR_CMP_CTL, 8'h07);
      wr(gpio_ef_pkg::ADDR_ANALOG_CFG, 8'h0f);
      wr(gpio_ef_pkg::ADDR_F_PINS, 8'ha5);
      rchk(gpio_ef_pkg::ADDR_F_LAT, 8'ha5);
      wr(gpio_ef_pkg::ADDR_F_DIR, 8'h0f);
      settle(2);
      cmp(portFOe, 8'hf0);
      cmp(portFOut & 8'hf0, 8'ha0);
      settle(6);
      // The host holds the released low nibble high, the device drives the high nibble.
      rchk(gpio_ef_pkg::ADDR_F_PINS, 8'haf);
      rchk(gpio_ef_pkg::ADDR_F_LAT, 8'ha5);
      cmp({7'h00, serialSelectN}, 8'h01);
      wr(gpio_ef_pkg::ADDR_F_DIR, 8'hff);
      $display("port F test done");
      settle(1);
      cmp(portEOe, 8'hff);
      cmp(portEOut, 8'h3c);
      cmp(extBusIn, 8'h3c);
      cmp({7'h00, extBusActive}, 8'h01);
      wr(gpio_ef_pkg::ADDR_MEM_CTL, 8'h80);
      wr(gpio_ef_pkg::ADDR_E_DIR, 8'h00);
      wr(gpio_ef_pkg::ADDR_E_PINS, 8'h96);
      settle(2);
      cmp(portEOut, 8'h96);
      cmp(portEOe, 8'hff);
      cmp({7'h00, extBusActive}, 8'h00);
      rchk(gpio_ef_pkg::ADDR_E_LAT, 8'h96);
      rchk(gpio_ef_pkg::ADDR_E_PINS, 8'h96);
      rchk(gpio_ef_pkg::ADDR_MEM_CTL, 8'h80);
      wr(gpio_ef_pkg::ADDR_E_DIR, 8'hff);
      settle(2);
      cmp(portEOe, 8'h00);
      $display("port E test done");
      @(posedge ref_clk);
      {pwmEnable, pwmB, pwmC, ccpOe, ccpOut} <= 5'b11011;
      wr(gpio_ef_pkg::ADDR_DEV_CFG, 8'h05);
      settle(4);
      cmp(portEOe & 8'he0, 8'he0);
      cmp(portEOut & 8'he0, 8'hc0);
      cmp({7'h00, ccpIn}, 8'h01);
      wr(gpio_ef_pkg::ADDR_DEV_CFG, 8'h07);
      settle(2);
      cmp(portEOe & 8'he0, 8'h80);
      wr(gpio_ef_pkg::ADDR_DEV_CFG, 8'h01);
      {pwmEnable, ccpOe} <= 2'b00;
      cmpOneResult <= 1'b1;
      wr(gpio_ef_pkg::ADDR_CMP_CTL, 8'hc6);
      settle(2);
      cmp(portFOe & 8'h06, 8'h06);
      cmp(portFOut & 8'h06, 8'h04);
      rchk(gpio_ef_pkg::ADDR_CMP_CTL, 8'h46);
      wr(gpio_ef_pkg::ADDR_CMP_CTL, 8'h07);
      $display("alternate function test done");
      wr(gpio_ef_pkg::ADDR_SP_CTL, 8'h10);
      pin_host_model_i.host_cycle(1, 1'b0, 8'h5e, o, d);
      rchk(gpio_ef_pkg::ADDR_SP_CTL, 8'h90);
      rchk(gpio_ef_pkg::ADDR_SLAVE_DATA, 8'h5e);
      pin_host_model_i.host_cycle(1, 1'b1, 8'h11, o, d);
      rchk(gpio_ef_pkg::ADDR_SP_CTL, 8'h10);
      wr(gpio_ef_pkg::ADDR_SLAVE_DATA, 8'hc3);
      rchk(gpio_ef_pkg::ADDR_SP_CTL, 8'h50);
      pin_host_model_i.host_cycle(0, 1'b0, 8'h00, o, d);
      cmp({7'h00, o}, 8'h01);
      cmp(d, 8'hc3);
      rchk(gpio_ef_pkg::ADDR_SP_CTL, 8'h10);
      pin_host_model_i.host_cycle(1, 1'b0, 8'ha1, o, d);
      pin_host_model_i.host_cycle(1, 1'b0, 8'ha2, o, d);
      rchk(gpio_ef_pkg::ADDR_SP_CTL, 8'hb0);
      $display("slave port test done");
      end_of_test();
   end
endmodule : gpio_ports_e_f_bench

bind gpio_ports_e_f gpio_ports_e_f_props gpio_ports_e_f_props_i (.ref_clk, .resetn, .regAddr,
   .regWrData, .regWr, .regRd, .regRdData, .portEOut, .portEOe, .portEIn, .portFOe, .portFIn,
   .extBusOut, .extBusOe, .extBusActive, .slaveDataOe, .serialSelectN);
`default_nettype wire
